// *** hdl/cz_pkg.sv ***
// Purpose: Shared types, constants and decode helpers for the operand execute unit
// Assumes: One clock, synchronous active-high reset
// Notes:   Register bus map and cycle counts live here
package cz_pkg;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic pv;
    logic d;
    logic h;
  } cz_flags_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } cz_bus_req_t;

  typedef enum logic [2:0] {
    CZ_OP_ADD = 3'b001,
    CZ_OP_ADC = 3'b010,
    CZ_OP_AND = 3'b100
  } cz_op_t;

  typedef enum logic [1:0] {
    CZ_SZ_BYTE = 2'h0,
    CZ_SZ_WORD = 2'h1,
    CZ_SZ_LONG = 2'h2
  } cz_size_t;

  typedef enum logic [2:0] {
    CZ_MD_REG = 3'h0,
    CZ_MD_IMM = 3'h1,
    CZ_MD_IND = 3'h2,
    CZ_MD_DIR = 3'h3,
    CZ_MD_IDX = 3'h4
  } cz_mode_t;

  typedef struct packed {
    logic       legal;
    cz_op_t     op;
    cz_size_t   size;
    cz_mode_t   mode;
    logic [3:0] src;
    logic [3:0] dst;
  } cz_dec_t;

  // ************************************************************
  // Register bus map
  // ************************************************************
  localparam logic [5:0]  CZ_ADDR_FLAGS  = 6'h10;
  localparam logic [5:0]  CZ_ADDR_CTRL   = 6'h11;
  localparam logic [5:0]  CZ_ADDR_COND   = 6'h12;
  localparam logic [5:0]  CZ_ADDR_STATUS = 6'h13;
  localparam int          CZ_CTRL_SEG    = 0;
  localparam int          CZ_COND_RES    = 0;
  localparam int          CZ_COND_LSB    = 1;
  localparam int          CZ_STAT_BUSY   = 0;
  localparam logic [15:0] CZ_REG_RST     = 16'h0000;
  localparam logic [5:0]  CZ_FLAGS_RST   = 6'h00;
  localparam logic [3:0]  CZ_COND_RST    = 4'h0;

  // ************************************************************
  // Cycle counts
  // ************************************************************
  localparam logic [4:0] CZ_CYC_RR      = 5'h04;
  localparam logic [4:0] CZ_CYC_ADC     = 5'h05;
  localparam logic [4:0] CZ_CYC_RR_L    = 5'h08;
  localparam logic [4:0] CZ_CYC_IM      = 5'h07;
  localparam logic [4:0] CZ_CYC_IM_L    = 5'h0E;
  localparam logic [4:0] CZ_CYC_DA_N    = 5'h09;
  localparam logic [4:0] CZ_CYC_DA_N_L  = 5'h0F;
  localparam logic [4:0] CZ_CYC_SS      = 5'h0A;
  localparam logic [4:0] CZ_CYC_SS_L    = 5'h10;
  localparam logic [4:0] CZ_CYC_X_N_L   = 5'h10;
  localparam logic [4:0] CZ_CYC_SL_GAIN = 5'h02;
  localparam logic [4:0] CZ_CYC_SL_XADD = 5'h01;

  // Condition field codes
  localparam logic [3:0] CZ_CC_NEVER  = 4'h0;
  localparam logic [3:0] CZ_CC_SLT    = 4'h1;
  localparam logic [3:0] CZ_CC_SLE    = 4'h2;
  localparam logic [3:0] CZ_CC_ULE    = 4'h3;
  localparam logic [3:0] CZ_CC_OV     = 4'h4;
  localparam logic [3:0] CZ_CC_MINUS  = 4'h5;
  localparam logic [3:0] CZ_CC_ZERO   = 4'h6;
  localparam logic [3:0] CZ_CC_CARRY  = 4'h7;
  localparam logic [3:0] CZ_CC_ALWAYS = 4'h8;
  localparam logic [3:0] CZ_CC_SGE    = 4'h9;
  localparam logic [3:0] CZ_CC_SGT    = 4'hA;
  localparam logic [3:0] CZ_CC_UGT    = 4'hB;
  localparam logic [3:0] CZ_CC_NOV    = 4'hC;
  localparam logic [3:0] CZ_CC_PLUS   = 4'hD;
  localparam logic [3:0] CZ_CC_NZERO  = 4'hE;
  localparam logic [3:0] CZ_CC_NCARRY = 4'hF;

  // Byte code: 0..7 high bytes, 8..15 low bytes of word registers 0..7
  function automatic logic [3:0] cz_byte_idx(input logic [3:0] code);
    return {1'b0, code[2:0]};
  endfunction : cz_byte_idx

  // Pairs start on an even register
  function automatic logic [3:0] cz_pair_idx(input logic [3:0] code);
    return {code[3:1], 1'b0};
  endfunction : cz_pair_idx

  // Only C, Z, S and P/V take part
  function automatic logic cz_cond(input logic [3:0] cc, input cz_flags_t f);
    logic sv;
    sv = f.s ^ f.pv;
    unique case (cc)
      CZ_CC_NEVER:  return 1'b0;
      CZ_CC_SLT:    return sv;
      CZ_CC_SLE:    return f.z | sv;
      CZ_CC_ULE:    return f.c | f.z;
      CZ_CC_OV:     return f.pv;
      CZ_CC_MINUS:  return f.s;
      CZ_CC_ZERO:   return f.z;
      CZ_CC_CARRY:  return f.c;
      CZ_CC_ALWAYS: return 1'b1;
      CZ_CC_SGE:    return ~sv;
      CZ_CC_SGT:    return ~(f.z | sv);
      CZ_CC_UGT:    return ~f.c & ~f.z;
      CZ_CC_NOV:    return ~f.pv;
      CZ_CC_PLUS:   return ~f.s;
      CZ_CC_NZERO:  return ~f.z;
      CZ_CC_NCARRY: return ~f.c;
    endcase
  endfunction : cz_cond

endpackage : cz_pkg

// *** hdl/cz_alu.sv ***
// Purpose: Add, add-with-carry and logical AND with flag results
// Assumes: Operands right-aligned to the operation size
// Notes:   Purely combinational
`timescale 1ns/100ps
module cz_alu
  import cz_pkg::*;
(
  input  wire cz_op_t      op_in,
  input  wire cz_size_t    size_in,
  input  wire logic [31:0] dst_in,
  input  wire logic [31:0] src_in,
  input  wire cz_flags_t   flags_in,
  output      logic [31:0] res_out,
  output      cz_flags_t   flags_out
);

  logic        cin;
  logic [8:0]  sum_b;
  logic [4:0]  sum_h;
  logic [16:0] sum_w;
  logic [32:0] sum_l;
  logic [31:0] and_r;

  assign cin   = (op_in == CZ_OP_ADC) ? flags_in.c : 1'b0;
  assign sum_b = {1'b0, dst_in[7:0]} + {1'b0, src_in[7:0]} + {8'h00, cin};
  assign sum_h = {1'b0, dst_in[3:0]} + {1'b0, src_in[3:0]} + {4'h0, cin};
  assign sum_w = {1'b0, dst_in[15:0]} + {1'b0, src_in[15:0]} + {16'h0000, cin};
  assign sum_l = {1'b0, dst_in} + {1'b0, src_in} + {32'h0000_0000, cin};
  assign and_r = dst_in & src_in;

  always_comb begin
    res_out   = 32'h0000_0000;
    flags_out = flags_in;
    unique case (size_in)
      CZ_SZ_BYTE: begin
        if (op_in == CZ_OP_AND) begin
          res_out[7:0] = and_r[7:0];
          flags_out.pv = ~^and_r[7:0];
        end else begin
          res_out[7:0] = sum_b[7:0];
          flags_out.c  = sum_b[8];
          flags_out.pv = (dst_in[7] == src_in[7]) && (sum_b[7] != dst_in[7]);
          flags_out.h  = sum_h[4];
          flags_out.d  = 1'b0;
        end
        flags_out.z = (res_out[7:0] == 8'h00);
        flags_out.s = res_out[7];
      end
      CZ_SZ_WORD: begin
        if (op_in == CZ_OP_AND) begin
          res_out[15:0] = and_r[15:0];
        end else begin
          res_out[15:0] = sum_w[15:0];
          flags_out.c   = sum_w[16];
          flags_out.pv  = (dst_in[15] == src_in[15]) && (sum_w[15] != dst_in[15]);
        end
        flags_out.z = (res_out[15:0] == 16'h0000);
        flags_out.s = res_out[15];
      end
      CZ_SZ_LONG: begin
        res_out      = sum_l[31:0];
        flags_out.c  = sum_l[32];
        flags_out.pv = (dst_in[31] == src_in[31]) && (sum_l[31] != dst_in[31]);
        flags_out.z  = (sum_l[31:0] == 32'h0000_0000);
        flags_out.s  = sum_l[31];
      end
      default: begin
        res_out = 32'h0000_0000;
      end
    endcase
  end

endmodule : cz_alu

// *** hdl/cz_exec.sv ***
// Purpose: Decode and execute add, add-with-carry and AND with register file
// Assumes: Instruction words arrive with a valid strobe, memory answers later
// Notes:   Register file and flags are also reachable over the register port
//
// Notes on behaviour
// - Size bit 1 selects word operation, 0 selects byte operation.
// - Four-bit word field n selects register n, 0 to 15.
// - Byte codes 0-7 pick high bytes, 8-15 low bytes of 0-7.
// - Pair fields name even registers; quadruples start at 0, 4, 8, 12.
// - Address registers are words unsegmented, pairs when segmented.
// - Code 0 never, 8 always, 6 on zero, 14 on not zero.
// - Code 7 carry, 15 no carry, 13 sign clear, 5 sign set.
// - Code 4 on parity/overflow set, 12 on it clear.
// - Signed: 9, 1, 10, 2 from sign xor overflow and zero.
// - Unsigned: 11 when carry and zero clear, 3 when either set.
// - Add-with-carry adds carry in, keeps source, chains multiword sums.
// - Adds set carry, zero and sign from the result, else clear.
// - Overflow set when like-signed operands give opposite-sign result.
// - Byte add sets half-carry from bit 3; wider adds keep it.
// - AND stores bitwise AND, sets zero and sign; byte form parity.
// - Register add decodes 1000000W, source then destination, 4 cycles.
// - Register add-with-carry decodes 1011010W and takes 5 cycles.
// - Register AND decodes 1000011W and takes 4 cycles.
// - Word add immediate decodes 00000001, zero field, one word, 7 cycles.
// - Segmented direct accepts short and long forms; long costs two more.
// - Byte logic sets parity flag on even count of ones.
// - Condition test uses carry, zero, sign and parity/overflow only.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
module cz_exec
  import cz_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        instr_valid_in,
  input  wire logic [15:0] instr_word_in,
  output      logic        ready_out,
  output      logic        mem_rd_out,
  output      logic [31:0] mem_addr_out,
  input  wire logic        mem_valid_in,
  input  wire logic [15:0] mem_data_in,
  output      logic        done_out,
  output      logic        illegal_out,
  input  wire cz_bus_req_t bus_in,
  output      logic [15:0] bus_rdata_out,
  output      logic        cond_true_out
);

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_ADDR  = 5'b00100,
    ST_MEM   = 5'b01000,
    ST_EXEC  = 5'b10000
  } cz_state_t;

  cz_state_t   state_q;
  cz_dec_t     dec_q;
  cz_dec_t     dec_w;
  logic [15:0] regs_q [16];
  cz_flags_t   flags_q;
  logic        seg_q;
  logic        seg_ins_q;
  logic [3:0]  cc_q;
  logic [15:0] ext_q [2];
  logic        ext_idx_q;
  logic [1:0]  ext_left_q;
  logic        long_addr_q;
  logic        mem_idx_q;
  logic [31:0] opnd_q;
  logic [4:0]  cyc_q;
  logic [4:0]  total_w;
  logic [31:0] ea_w;
  logic [31:0] dst_w;
  logic [31:0] src_w;
  logic [31:0] res_w;
  cz_flags_t   flags_w;
  logic        take_w;
  logic        finish_w;
  logic [3:0]  dp_w;
  logic [3:0]  sp_w;

  // ************************************************************
  // Decode
  // ************************************************************
  function automatic cz_dec_t decode(input logic [15:0] w);
    cz_dec_t d;
    logic    nz;
    d       = '0;
    d.op    = CZ_OP_ADD;
    d.src   = w[7:4];
    d.dst   = w[3:0];
    d.size  = w[8] ? CZ_SZ_WORD : CZ_SZ_BYTE;
    nz      = (w[7:4] != 4'h0);
    d.legal = 1'b1;
    unique case (w[15:14])
      2'b10:   d.mode = CZ_MD_REG;
      2'b00:   d.mode = nz ? CZ_MD_IND : CZ_MD_IMM;
      2'b01:   d.mode = nz ? CZ_MD_IDX : CZ_MD_DIR;
      default: d.legal = 1'b0;
    endcase
    casez (w[13:8])
      6'b00000?: d.op = CZ_OP_ADD;
      6'b00011?: d.op = CZ_OP_AND;
      6'b010110: d.size = CZ_SZ_LONG;
      6'b11010?: begin
        d.op    = CZ_OP_ADC;
        d.legal = d.legal && (d.mode == CZ_MD_REG);
      end
      default:   d.legal = 1'b0;
    endcase
    return d;
  endfunction : decode

  function automatic logic [4:0] cycles(input cz_dec_t d, input logic seg, input logic sl);
    logic lng;
    lng = (d.size == CZ_SZ_LONG);
    unique case (d.mode)
      CZ_MD_REG: return lng ? CZ_CYC_RR_L : ((d.op == CZ_OP_ADC) ? CZ_CYC_ADC : CZ_CYC_RR);
      CZ_MD_IMM, CZ_MD_IND: return lng ? CZ_CYC_IM_L : CZ_CYC_IM;
      CZ_MD_DIR: begin
        if (!seg) return lng ? CZ_CYC_DA_N_L : CZ_CYC_DA_N;
        return (lng ? CZ_CYC_SS_L : CZ_CYC_SS) + (sl ? CZ_CYC_SL_GAIN : 5'h00);
      end
      CZ_MD_IDX: begin
        if (!seg) return lng ? CZ_CYC_X_N_L : CZ_CYC_SS;
        return (lng ? CZ_CYC_SS_L : CZ_CYC_SS) + (sl ? (CZ_CYC_SL_GAIN + CZ_CYC_SL_XADD) : 5'h00);
      end
      default: return CZ_CYC_RR;
    endcase
  endfunction : cycles

  assign dec_w    = decode(instr_word_in);
  assign take_w   = (state_q == ST_IDLE) && instr_valid_in;
  assign total_w  = cycles(dec_q, seg_ins_q, long_addr_q);
  assign finish_w = (state_q == ST_EXEC) && (cyc_q >= total_w - 5'h01);
  assign dp_w     = cz_pair_idx(dec_q.dst);
  assign sp_w     = cz_pair_idx(dec_q.src);

  // ************************************************************
  // Operands and effective address
  // ************************************************************
  always_comb begin
    dst_w = 32'h0000_0000;
    src_w = 32'h0000_0000;
    unique case (dec_q.size)
      CZ_SZ_BYTE: begin
        dst_w[7:0] = dec_q.dst[3] ? regs_q[cz_byte_idx(dec_q.dst)][7:0]
                                  : regs_q[cz_byte_idx(dec_q.dst)][15:8];
        src_w[7:0] = dec_q.src[3] ? regs_q[cz_byte_idx(dec_q.src)][7:0]
                                  : regs_q[cz_byte_idx(dec_q.src)][15:8];
      end
      CZ_SZ_WORD: begin
        dst_w[15:0] = regs_q[dec_q.dst];
        src_w[15:0] = regs_q[dec_q.src];
      end
      CZ_SZ_LONG: begin
        dst_w = {regs_q[dp_w], regs_q[dp_w | 4'h1]};
        src_w = {regs_q[sp_w], regs_q[sp_w | 4'h1]};
      end
      default: dst_w = 32'h0000_0000;
    endcase
    if (dec_q.mode == CZ_MD_IMM) begin
      unique case (dec_q.size)
        CZ_SZ_BYTE: src_w = {24'h000000, ext_q[0][7:0]};
        CZ_SZ_WORD: src_w = {16'h0000, ext_q[0]};
        default:    src_w = {ext_q[0], ext_q[1]};
      endcase
    end else if (dec_q.mode != CZ_MD_REG) begin
      src_w = opnd_q;
    end
  end

  // Segmented addresses are {0, segment, 8'h00, offset}
  always_comb begin
    ea_w = 32'h0000_0000;
    unique case (dec_q.mode)
      CZ_MD_IND: ea_w = seg_ins_q ? {regs_q[sp_w], regs_q[sp_w | 4'h1]}
                                  : {16'h0000, regs_q[dec_q.src]};
      CZ_MD_DIR, CZ_MD_IDX: begin
        if (!seg_ins_q)
          ea_w = {16'h0000, ext_q[0]};
        else if (long_addr_q)
          ea_w = {1'b0, ext_q[0][14:8], 8'h00, ext_q[1]};
        else
          ea_w = {1'b0, ext_q[0][14:8], 8'h00, 8'h00, ext_q[0][7:0]};
        if (dec_q.mode == CZ_MD_IDX)
          ea_w[15:0] = ea_w[15:0] + regs_q[dec_q.src];
      end
      default: ea_w = 32'h0000_0000;
    endcase
  end

  cz_alu i_cz_alu (
    .op_in     (dec_q.op),
    .size_in   (dec_q.size),
    .dst_in    (dst_w),
    .src_in    (src_w),
    .flags_in  (flags_q),
    .res_out   (res_w),
    .flags_out (flags_w)
  );

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q     <= ST_IDLE;
      dec_q       <= '0;
      seg_ins_q   <= 1'b0;
      ext_idx_q   <= 1'b0;
      ext_left_q  <= 2'h0;
      long_addr_q <= 1'b0;
      cyc_q       <= 5'h00;
    end else begin
      if (state_q != ST_IDLE && cyc_q != 5'h1F)
        cyc_q <= cyc_q + 5'h01;
      unique case (state_q)
        ST_IDLE: begin
          if (take_w && dec_w.legal) begin
            dec_q       <= dec_w;
            seg_ins_q   <= seg_q;
            cyc_q       <= 5'h01;
            ext_idx_q   <= 1'b0;
            long_addr_q <= 1'b0;
            ext_left_q  <= (dec_w.mode == CZ_MD_IMM && dec_w.size == CZ_SZ_LONG) ? 2'h2
                                                                                 : 2'h1;
            unique case (dec_w.mode)
              CZ_MD_REG: state_q <= ST_EXEC;
              CZ_MD_IND: state_q <= ST_ADDR;
              default:   state_q <= ST_FETCH;
            endcase
          end
        end
        ST_FETCH: begin
          if (instr_valid_in) begin
            ext_idx_q <= 1'b1;
            if (!ext_idx_q && seg_ins_q && dec_q.mode != CZ_MD_IMM && instr_word_in[15]) begin
              long_addr_q <= 1'b1;
            end else if (ext_left_q == 2'h1) begin
              state_q <= (dec_q.mode == CZ_MD_IMM) ? ST_EXEC : ST_ADDR;
            end
            if (!(!ext_idx_q && seg_ins_q && dec_q.mode != CZ_MD_IMM && instr_word_in[15]))
              ext_left_q <= ext_left_q - 2'h1;
          end
        end
        ST_ADDR: state_q <= ST_MEM;
        ST_MEM: begin
          if (mem_valid_in && (mem_idx_q || dec_q.size != CZ_SZ_LONG))
            state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          if (finish_w)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Extension words, high word of a long immediate first
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ext_q[0] <= CZ_REG_RST;
      ext_q[1] <= CZ_REG_RST;
    end else if (state_q == ST_FETCH && instr_valid_in) begin
      ext_q[ext_idx_q] <= instr_word_in;
    end
  end

  // ************************************************************
  // Memory operand
  // ************************************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mem_rd_out   <= 1'b0;
      mem_addr_out <= 32'h0000_0000;
      mem_idx_q    <= 1'b0;
      opnd_q       <= 32'h0000_0000;
    end else begin
      mem_rd_out <= 1'b0;
      if (state_q == ST_ADDR) begin
        mem_rd_out   <= 1'b1;
        mem_addr_out <= ea_w;
        mem_idx_q    <= 1'b0;
        opnd_q       <= 32'h0000_0000;
      end else if (state_q == ST_MEM && mem_valid_in) begin
        unique case (dec_q.size)
          CZ_SZ_BYTE: opnd_q[7:0] <= mem_addr_out[0] ? mem_data_in[7:0] : mem_data_in[15:8];
          CZ_SZ_WORD: opnd_q[15:0] <= mem_data_in;
          default: begin
            if (mem_idx_q) begin
              opnd_q[15:0] <= mem_data_in;
            end else begin
              opnd_q[31:16]      <= mem_data_in;
              mem_idx_q          <= 1'b1;
              mem_rd_out         <= 1'b1;
              mem_addr_out[15:0] <= mem_addr_out[15:0] + 16'h0002;
            end
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Register file and flags
  // ************************************************************
  // A bus write in the finishing cycle wins over the result
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 16; i++)
        regs_q[i] <= CZ_REG_RST;
    end else begin
      if (finish_w) begin
        unique case (dec_q.size)
          CZ_SZ_BYTE: begin
            if (dec_q.dst[3])
              regs_q[cz_byte_idx(dec_q.dst)][7:0] <= res_w[7:0];
            else
              regs_q[cz_byte_idx(dec_q.dst)][15:8] <= res_w[7:0];
          end
          CZ_SZ_WORD: regs_q[dec_q.dst] <= res_w[15:0];
          default: begin
            regs_q[dp_w]        <= res_w[31:16];
            regs_q[dp_w | 4'h1] <= res_w[15:0];
          end
        endcase
      end
      if (bus_in.wr && bus_in.addr[5:4] == 2'b00)
        regs_q[bus_in.addr[3:0]] <= bus_in.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      flags_q <= CZ_FLAGS_RST;
    end else if (bus_in.wr && bus_in.addr == CZ_ADDR_FLAGS) begin
      flags_q <= bus_in.wdata[5:0];
    end else if (finish_w) begin
      flags_q <= flags_w;
    end
  end

  // ************************************************************
  // Control, condition query and read port
  // ************************************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      seg_q <= 1'b0;
      cc_q  <= CZ_COND_RST;
    end else if (bus_in.wr) begin
      if (bus_in.addr == CZ_ADDR_CTRL)
        seg_q <= bus_in.wdata[CZ_CTRL_SEG];
      if (bus_in.addr == CZ_ADDR_COND)
        cc_q <= bus_in.wdata[CZ_COND_LSB +: 4];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cond_true_out <= 1'b0;
      bus_rdata_out <= 16'h0000;
    end else begin
      cond_true_out <= cz_cond(cc_q, flags_q);
      bus_rdata_out <= 16'h0000;
      if (bus_in.rd) begin
        if (bus_in.addr[5:4] == 2'b00)
          bus_rdata_out <= regs_q[bus_in.addr[3:0]];
        else if (bus_in.addr == CZ_ADDR_FLAGS)
          bus_rdata_out <= {10'h000, flags_q};
        else if (bus_in.addr == CZ_ADDR_CTRL)
          bus_rdata_out <= {15'h0000, seg_q};
        else if (bus_in.addr == CZ_ADDR_COND)
          bus_rdata_out <= {11'h000, cc_q, cz_cond(cc_q, flags_q)};
        else if (bus_in.addr == CZ_ADDR_STATUS)
          bus_rdata_out <= {15'h0000, state_q != ST_IDLE};
      end
    end
  end

  // ************************************************************
  // Handshake outputs
  // ************************************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ready_out   <= 1'b1;
      done_out    <= 1'b0;
      illegal_out <= 1'b0;
    end else begin
      done_out    <= finish_w;
      illegal_out <= take_w && !dec_w.legal;
      if (take_w && dec_w.legal)
        ready_out <= (dec_w.mode != CZ_MD_REG) && (dec_w.mode != CZ_MD_IND);
      else if (state_q == ST_FETCH && instr_valid_in && ext_left_q == 2'h1 &&
               !(!ext_idx_q && seg_ins_q && dec_q.mode != CZ_MD_IMM && instr_word_in[15]))
        ready_out <= 1'b0;
      else if (finish_w)
        ready_out <= 1'b1;
    end
  end

endmodule : cz_exec

// *** tb/cz_exec_chk.sv ***
// Purpose: Port checks for the execute unit
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into cz_exec at the foot of this file
`timescale 1ns/100ps
module cz_exec_chk
  import cz_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        instr_valid_in,
  input wire logic [15:0] instr_word_in,
  input wire logic        ready_out,
  input wire logic        done_out,
  input wire logic        illegal_out,
  input wire cz_bus_req_t bus_in,
  input wire logic [15:0] bus_rdata_out,
  input wire logic        cond_true_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  logic tk;
  // First words only: extension words must not match these opcodes
  assign tk = instr_valid_in && ready_out;
  // ******
  // Checks
  // ******
  add_rr_cyc_a: assert property (
    tk && instr_word_in[15:9] == 7'h40 |=> !ready_out [*3] ##1 done_out)
    else $error("Register add timing wrong");
  adc_rr_cyc_a: assert property (
    tk && instr_word_in[15:9] == 7'h5A |-> ##5 done_out)
    else $error("Add with carry timing wrong");
  and_rr_cyc_a: assert property (
    tk && instr_word_in[15:9] == 7'h43 |-> ##4 done_out)
    else $error("Register and timing wrong");
  add_imm_cyc_a: assert property (
    tk && instr_word_in[15:4] == 12'h010 ##1 tk |-> ##6 done_out)
    else $error("Immediate add timing wrong");
  done_pulse_a: assert property (
    done_out |-> ready_out ##1 !done_out)
    else $error("Done not a single pulse");
  bad_op_a: assert property (
    illegal_out |-> ready_out && !done_out ##1 !illegal_out)
    else $error("Illegal opcode handling wrong");
  cc_never_a: assert property (
    bus_in.wr && bus_in.addr == CZ_ADDR_COND && bus_in.wdata[4:1] == CZ_CC_NEVER
    |-> ##2 !cond_true_out) else $error("Never code came true");
  cc_always_a: assert property (
    bus_in.wr && bus_in.addr == CZ_ADDR_COND && bus_in.wdata[4:1] == CZ_CC_ALWAYS
    |-> ##2 cond_true_out) else $error("Always code came false");
  cover property (done_out);
  cover property (illegal_out);
  cover property (cond_true_out);
endmodule : cz_exec_chk

bind cz_exec cz_exec_chk i_cz_exec_chk (.clk_in(clk_in), .reset_in(reset_in),
  .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in), .ready_out(ready_out),
  .done_out(done_out), .illegal_out(illegal_out), .bus_in(bus_in),
  .bus_rdata_out(bus_rdata_out), .cond_true_out(cond_true_out));

// *** tb/tb_top.sv ***
// Purpose: Directed bench for the execute unit
// Assumes: Register, immediate and nonsegmented indirect forms
// Notes:   Memory answers a read one cycle later with its address as data
`timescale 1ns/100ps
module tb_top
  import cz_pkg::*;
;
  logic        clk_in     = 1'b0;
  logic        reset_in   = 1'b1;
  logic        iv         = 1'b0;
  logic [15:0] iw         = 16'h0000;
  cz_bus_req_t bus        = '0;
  logic [15:0] rdata;
  logic        rdy, done, ill, ct;
  logic        mr;
  logic [31:0] ma;
  logic        mv         = 1'b0;
  int          fails      = 0;
  int          num_checks = 0;
  always #2 clk_in = ~clk_in;
  // One-cycle memory latency, so the unit must wait in its memory state
  always @(posedge clk_in) mv <= mr;
  cz_exec i_cz_exec (.clk_in(clk_in), .reset_in(reset_in), .instr_valid_in(iv),
    .instr_word_in(iw), .ready_out(rdy), .mem_rd_out(mr), .mem_addr_out(ma),
    .mem_valid_in(mv), .mem_data_in(ma[15:0]), .done_out(done), .illegal_out(ill),
    .bus_in(bus), .bus_rdata_out(rdata), .cond_true_out(ct));
  // ******
  // Tasks
  // ******
  task automatic test_done();
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk_in);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_in);
    bus <= '0;
    @(negedge clk_in);
    chk(rdata, e);
  endtask : rd
  // Counts cycles from the first word to done; a hang ends the run
  task automatic exe(input logic [15:0] w, input logic [15:0] x, input bit ne, input int cyc);
    int k;
    @(posedge clk_in);
    iv <= 1'b1;
    iw <= w;
    for (k = 0; k < 40; k++) begin
      @(negedge clk_in);
      if (done === 1'b1) break;
      @(posedge clk_in);
      if (k == 0 && ne) iw <= x;
      else iv <= 1'b0;
    end
    chk(16'(k), 16'(cyc));
    if (k == 40) test_done();
  endtask : exe
  // Own table: low three bits pick the test, top bit inverts it
  function automatic logic exp_cc(input logic [3:0] c, input logic [5:0] f);
    logic v;
    case (c[2:0])
      3'h0: v = 1'b0;
      3'h1: v = f[3] ^ f[2];
      3'h2: v = f[4] | (f[3] ^ f[2]);
      3'h3: v = f[5] | f[4];
      3'h4: v = f[2];
      3'h5: v = f[3];
      3'h6: v = f[4];
      default: v = f[5];
    endcase
    return v ^ c[3];
  endfunction : exp_cc
  task automatic t_cond(input logic [5:0] f);
    wr(CZ_ADDR_FLAGS, {10'h000, f});
    for (int i = 0; i < 16; i++) begin
      wr(CZ_ADDR_COND, {11'h000, i[3:0], 1'b0});
      rd(CZ_ADDR_COND, {11'h000, i[3:0], exp_cc(i[3:0], f)});
      chk({15'h0000, ct}, {15'h0000, exp_cc(i[3:0], f)});
    end
  endtask : t_cond
  // ******
  // Main
  // ******
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    wr(6'h01, 16'h7FFF);
    wr(6'h02, 16'h0001);
    exe(16'h8121, 16'h0000, 1'b0, 4);
    rd(6'h01, 16'h8000);
    rd(CZ_ADDR_FLAGS, 16'h000C);
    wr(6'h01, 16'hFFFF);
    wr(6'h02, 16'h4320);
    wr(6'h03, 16'h0001);
    exe(16'h8131, 16'h0000, 1'b0, 4);
    rd(CZ_ADDR_FLAGS, 16'h0030);
    exe(16'hB520, 16'h0000, 1'b0, 5);
    rd(6'h00, 16'h4321);
    rd(CZ_ADDR_FLAGS, 16'h0000);
    wr(6'h03, 16'hCEE7);
    wr(CZ_ADDR_FLAGS, 16'h0020);
    exe(16'h863B, 16'h0000, 1'b0, 4);
    rd(6'h03, 16'hCEC6);
    rd(CZ_ADDR_FLAGS, 16'h002C);
    wr(CZ_ADDR_FLAGS, 16'h0000);
    wr(6'h01, 16'h0F01);
    exe(16'h8019, 16'h0000, 1'b0, 4);
    rd(6'h01, 16'h0F10);
    rd(CZ_ADDR_FLAGS, 16'h0001);
    wr(6'h03, 16'h7FFF);
    exe(16'h0103, 16'h0001, 1'b1, 7);
    rd(6'h03, 16'h8000);
    rd(CZ_ADDR_FLAGS, 16'h000D);
    @(posedge clk_in);
    iv <= 1'b1;
    iw <= 16'hFFFF;
    @(posedge clk_in);
    iv <= 1'b0;
    @(negedge clk_in);
    chk({15'h0000, ill}, 16'h0001);
    rd(6'h00, 16'h4321);
    rd(6'h3F, 16'h0000);
    wr(6'h04, 16'h0040);
    wr(6'h05, 16'h0001);
    exe(16'h0145, 16'h0000, 1'b0, 7);
    chk(ma[15:0], 16'h0040);
    chk(ma[31:16], 16'h0000);
    rd(6'h05, 16'h0041);
    t_cond(6'h00);
    t_cond(6'h3C);
    t_cond(6'h28);
    t_cond(6'h13);
    t_cond(6'h24);
    test_done();
  end
endmodule : tb_top
